// *** i2cb_core.sv ***
// Single-bit I2C interface with arbitration, stretching and bus-watch timeout
// Function
// - Move I2C traffic bit by bit; check arbitration and framing on each bit.
// - Stretch SCL and include a hardware bus timeout timer.
// - Expose status flags for polling and interrupt requests for software.
// - Bus interrupt enable sits at bit 0 of enable register B.
// - Watch-timer interrupt enable sits at bit 7 of enable register B.
// - Both interrupts carry a software-programmable priority level.
// - Raise bus-locked interrupt when the bus idles too long inside a frame.
// - Bus-watch timer guarantees the minimum bus timing spans.
// - Support multiple masters; arbitration must not corrupt bus data.
// - Every byte ends with an acknowledge; slaves selected by serial address (the core moves single bits only; bytes and addresses are left to software).
// - Full counter runs in a frame, carrying 1020 to 1023 cycles after SCL or SDA change.
// - Carry resets the interface, releases SCL and requests the timer interrupt.
// - Counter high part stopped between frames, after reset or stop, before next start.
// - After bit-ready sets on SCL rise, hold next SCL low until cleared.
`timescale 1ns/1ps
module i2cb_core
    import i2cb_pkg::*;
#(
    parameter int MCYCLE_DIV = MCYCLE_DIV_DEF
) (
    input wire logic MCLK,
    input wire logic ARST_N,
    input wire logic SCL_I,
    output logic SCL_O,
    output logic SCL_OE,
    input wire logic SDA_I,
    output logic SDA_O,
    output logic SDA_OE,
    input wire logic SLAVE_EN,
    input wire logic MASTER_REQ,
    input wire logic TIMER_RUN,
    input wire logic [1:0] PRESCALE,
    input wire i2cb_cmd_t CMD,
    output i2cb_stat_t STATUS,
    input wire logic GLOBAL_IRQ_ENABLE,
    input wire logic [7:0] IRQ_ENABLE_REG_B,
    input wire logic [1:0] BUS_PRIO_SET,
    input wire logic [1:0] TIMER_PRIO_SET,
    output logic BUS_IRQ,
    output logic TIMER_IRQ,
    output logic [1:0] BUS_IRQ_PRIO,
    output logic [1:0] TIMER_IRQ_PRIO
);

    localparam int DIV_W = $clog2(MCYCLE_DIV + 1);

    // Flag update where a set in the same cycle beats the clear
    function automatic logic flag_upd(input logic cur, input logic set, input logic clr);
        return set | (cur & ~clr);
    endfunction : flag_upd

    logic [DIV_W-1:0] div_r;
    logic scl_q_r;
    logic sda_q_r;
    i2cb_mst_t mst_r;
    i2cb_mst_t mst_nxt;
    logic master_r;
    logic in_frame_r;
    logic idle_r;
    logic xact_r;
    logic tx_bit_r;
    logic rx_bit_r;
    logic ready_r;
    logic arb_r;
    logic str_r;
    logic stp_r;
    logic xstr_r;
    logic xstp_r;
    logic hold_r;
    logic rel_r;
    logic tmo_r;
    logic bus_irq_r;
    logic timer_irq_r;
    logic [1:0] bus_prio_r;
    logic [1:0] timer_prio_r;
    logic min_ok;
    logic carry;

    // Machine-cycle enable pulse
    wire mtick = (div_r == DIV_W'(MCYCLE_DIV - 1));

    // Bus event decode from the previous sample
    wire scl_rise = SCL_I & ~scl_q_r;
    wire scl_fall = ~SCL_I & scl_q_r;
    wire scl_chg = SCL_I ^ scl_q_r;
    wire sda_chg = SDA_I ^ sda_q_r;
    wire start_det = SCL_I & scl_q_r & sda_q_r & ~SDA_I;
    wire stop_det = SCL_I & scl_q_r & ~sda_q_r & SDA_I;

    // Role and stretch conditions
    wire enabled = SLAVE_EN | MASTER_REQ | master_r;
    wire participate = master_r | (SLAVE_EN & ~idle_r);
    wire s_act = SLAVE_EN & ~idle_r & ~master_r & in_frame_r;
    wire hold_cond = ready_r | arb_r | str_r | stp_r;
    wire tx_release = ~xact_r | tx_bit_r;
    wire arb_loss = master_r & (mst_r == M_HIGH) & scl_rise
                  & xact_r & tx_bit_r & ~SDA_I;
    wire m_adv = (mst_r == M_LOW) & ~hold_cond & min_ok;
    wire kill = carry | arb_loss;
    wire mst_chg = (mst_nxt != mst_r);

    // Master sequencer next state
    always_comb begin
        mst_nxt = mst_r;
        case (mst_r)
            M_IDLE: begin
                if (MASTER_REQ && !in_frame_r && SCL_I && SDA_I && min_ok) begin
                    mst_nxt = M_START_A;
                end
            end
            M_START_A: begin
                if (SCL_I && min_ok && rel_r) begin
                    mst_nxt = M_START_B;
                end
            end
            M_START_B: begin
                if (min_ok) begin
                    mst_nxt = M_LOW;
                end
            end
            M_LOW: begin
                if (m_adv && xstp_r) begin
                    mst_nxt = M_STOP_A;
                end else if (m_adv && xstr_r) begin
                    mst_nxt = M_START_A;
                end else if (m_adv) begin
                    mst_nxt = M_HIGH;
                end
            end
            M_HIGH: begin
                if (SCL_I && min_ok) begin
                    mst_nxt = M_LOW;
                end
            end
            M_STOP_A: begin
                if (SCL_I && min_ok && rel_r) begin
                    mst_nxt = M_STOP_B;
                end
            end
            M_STOP_B: begin
                if (min_ok) begin
                    mst_nxt = M_IDLE;
                end
            end
            default: begin
                mst_nxt = M_IDLE;
            end
        endcase
        if (kill || !enabled) begin
            mst_nxt = M_IDLE;
        end
    end

    // Pin drive; both lines are open drain
    wire m_rel_state = (mst_r == M_START_A) | (mst_r == M_STOP_A);
    wire m_scl_low = (mst_r == M_LOW) | (m_rel_state & ~rel_r & in_frame_r);
    wire m_sda_low = (mst_r == M_START_B) | (mst_r == M_STOP_A)
                   | (((mst_r == M_LOW) | (mst_r == M_HIGH)) & ~tx_release);
    wire s_sda_low = s_act & ~tx_release;
    wire hold_nxt = s_act & hold_cond & (hold_r | scl_fall);
    assign SCL_O = 1'b0;
    assign SDA_O = 1'b0;
    assign SCL_OE = m_scl_low | hold_r;
    assign SDA_OE = m_sda_low | s_sda_low;

    // Flag next values
    wire ready_nxt = flag_upd(ready_r, scl_rise & participate,
                              CMD.clr_ready | CMD.wr_dat | CMD.rd_dat | kill | ~enabled);
    wire arb_nxt = flag_upd(arb_r, arb_loss, CMD.clr_arb);
    wire str_nxt = flag_upd(str_r, start_det & (master_r | SLAVE_EN), CMD.clr_start);
    wire stp_nxt = flag_upd(stp_r, stop_det & participate, CMD.clr_stop);
    wire xact_nxt = flag_upd(xact_r, CMD.wr_dat, CMD.rd_dat | CMD.clr_xact | kill);
    wire frame_nxt = flag_upd(in_frame_r, start_det, stop_det | carry);
    wire idle_nxt = flag_upd(idle_r, CMD.go_idle, start_det);
    wire mst_set = (mst_r == M_IDLE) & (mst_nxt == M_START_A);
    wire mst_done = (mst_r == M_STOP_B) & (mst_nxt == M_IDLE);
    wire master_nxt = flag_upd(master_r, mst_set, kill | mst_done);
    wire xstr_nxt = flag_upd(xstr_r, CMD.gen_start & master_r, kill | (m_adv & ~xstp_r));
    wire xstp_nxt = flag_upd(xstp_r, CMD.gen_stop & master_r, kill | m_adv);
    wire tmo_nxt = flag_upd(tmo_r, carry, CMD.clr_timeout);
    wire rel_nxt = ~mst_chg & (rel_r | min_ok);

    // Divider and bus samples
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            div_r <= '0;
            scl_q_r <= PIN_IDLE;
            sda_q_r <= PIN_IDLE;
        end else begin
            div_r <= mtick ? '0 : div_r + 1'b1;
            scl_q_r <= SCL_I;
            sda_q_r <= SDA_I;
        end
    end

    // Sequencer, roles and data bits
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            mst_r <= M_IDLE;
            master_r <= 1'b0;
            in_frame_r <= 1'b0;
            idle_r <= 1'b0;
            xact_r <= 1'b0;
            tx_bit_r <= 1'b1;
            rx_bit_r <= 1'b1;
            hold_r <= 1'b0;
            rel_r <= 1'b0;
        end else begin
            mst_r <= mst_nxt;
            master_r <= master_nxt;
            in_frame_r <= frame_nxt;
            idle_r <= idle_nxt;
            xact_r <= xact_nxt;
            tx_bit_r <= CMD.wr_dat ? CMD.tx_bit : tx_bit_r;
            rx_bit_r <= scl_rise ? SDA_I : rx_bit_r;
            hold_r <= hold_nxt & ~kill;
            rel_r <= rel_nxt;
        end
    end

    // Software flags and pending commands
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            ready_r <= 1'b0;
            arb_r <= 1'b0;
            str_r <= 1'b0;
            stp_r <= 1'b0;
            xstr_r <= 1'b0;
            xstp_r <= 1'b0;
            tmo_r <= 1'b0;
        end else begin
            ready_r <= ready_nxt;
            arb_r <= arb_nxt;
            str_r <= str_nxt;
            stp_r <= stp_nxt;
            xstr_r <= xstr_nxt;
            xstp_r <= xstp_nxt;
            tmo_r <= tmo_nxt;
        end
    end

    // Interrupt requests gated by own and global enables, with priority
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            bus_irq_r <= 1'b0;
            timer_irq_r <= 1'b0;
            bus_prio_r <= PRIO_RST;
            timer_prio_r <= PRIO_RST;
        end else begin
            bus_irq_r <= GLOBAL_IRQ_ENABLE & IRQ_ENABLE_REG_B[IRQ_BUS_BIT] & hold_cond;
            timer_irq_r <= GLOBAL_IRQ_ENABLE & IRQ_ENABLE_REG_B[IRQ_TIMER_BIT] & tmo_r;
            bus_prio_r <= BUS_PRIO_SET;
            timer_prio_r <= TIMER_PRIO_SET;
        end
    end

    assign BUS_IRQ = bus_irq_r;
    assign TIMER_IRQ = timer_irq_r;
    assign BUS_IRQ_PRIO = bus_prio_r;
    assign TIMER_IRQ_PRIO = timer_prio_r;

    // Status word; attention is any pending ready, arbitration, start or stop flag (not timeout)
    assign STATUS.rx_bit = rx_bit_r;
    assign STATUS.attn = hold_cond;
    assign STATUS.bit_ready = ready_r;
    assign STATUS.arb_lost = arb_r;
    assign STATUS.start_seen = str_r;
    assign STATUS.stop_seen = stp_r;
    assign STATUS.is_master = master_r;
    assign STATUS.timeout = tmo_r;

    // Bus-watch timer
    i2cb_watch u_watch (
        .clk(MCLK),
        .arst_n(ARST_N),
        .tick(mtick),
        .enable(enabled),
        .run_hi(TIMER_RUN & in_frame_r),
        .restart(scl_chg | sda_chg | mst_chg),
        .preload(PRELOAD_TBL[PRESCALE]),
        .min_ok(min_ok),
        .carry(carry)
    );

    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!ARST_N);

    AST_READY_ON_RISE: assert property (scl_rise && participate && !carry |=> STATUS.bit_ready)
        else $error("bit ready not set on SCL rise");
    AST_STRETCH: assert property (s_act && scl_fall && hold_cond && !kill |=> SCL_OE)
        else $error("SCL not held low while flags pending");
    AST_ARB_LOSS: assert property (arb_loss |=> STATUS.arb_lost && !STATUS.is_master && !SDA_OE)
        else $error("arbitration loss not handled");
    AST_TIMEOUT_RESET: assert property (carry |=> mst_r == M_IDLE && !SCL_OE && !in_frame_r)
        else $error("timeout did not reset the interface");
    AST_TIMER_IRQ: assert property (carry && GLOBAL_IRQ_ENABLE && IRQ_ENABLE_REG_B[7]
                                     && !CMD.clr_timeout ##1 GLOBAL_IRQ_ENABLE && IRQ_ENABLE_REG_B[7]
                                     |=> TIMER_IRQ)
        else $error("timer interrupt not requested after carry");
    AST_IRQ_GATE: assert property (BUS_IRQ || TIMER_IRQ |-> $past(GLOBAL_IRQ_ENABLE))
        else $error("interrupt without global enable");
    AST_BUS_IRQ_BIT0: assert property (BUS_IRQ |-> $past(IRQ_ENABLE_REG_B[0]) && $past(STATUS.attn))
        else $error("bus interrupt without its enable");
    AST_NO_CARRY_IDLE: assert property (!in_frame_r |-> !carry)
        else $error("watch carry between frames");
    AST_START_FLAG: assert property (start_det && master_r |=> STATUS.start_seen && in_frame_r)
        else $error("start not flagged");
    AST_PRIO: assert property (##1 BUS_IRQ_PRIO == $past(BUS_PRIO_SET) && TIMER_IRQ_PRIO == $past(TIMER_PRIO_SET))
        else $error("priority not taken");
    AST_TX_ZERO: assert property (master_r && xact_r && !tx_bit_r && (mst_r == M_LOW) |-> SDA_OE)
        else $error("zero data bit not driven");

endmodule : i2cb_core

// *** i2cb_core_tb.sv ***
// Self-checking bench for the single-bit I2C interface with bus-watch timeout
`timescale 1ns/1ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin fails++; \
    $display("wrong value %s expected %0h seen %0h", nm, e, g); end end
`define WAIT_UNTIL(cnd, lim) for (int k = 0; !(cnd); k++) begin \
    if (k >= lim) begin fails++; print_verdict(); end step(1); end
module i2cb_core_tb;
    import i2cb_pkg::*;
    logic mclk = 0, arst_n = 0, pull_scl = 0, pull_sda = 0, scl, sda, scl_oe, sda_oe;
    logic slave_en = 0, master_req = 0, timer_run = 0, gie = 0, bus_irq, tmr_irq;
    logic [1:0] prescale = 2'h0, bus_prio = 2'h0, tmr_prio = 2'h0, bus_ip, tmr_ip;
    logic [7:0] ien = 8'h00;
    i2cb_cmd_t cmd = '0, c;
    i2cb_stat_t status;
    int fails = 0, compares = 0, n;
    // Clock at 125 MHz
    always #4 mclk = ~mclk;
    i2cb_core #(.MCYCLE_DIV(1)) dut_u (.MCLK(mclk), .ARST_N(arst_n), .SCL_I(scl), .SCL_O(), .SCL_OE(scl_oe),
        .SDA_I(sda), .SDA_O(), .SDA_OE(sda_oe), .SLAVE_EN(slave_en), .MASTER_REQ(master_req),
        .TIMER_RUN(timer_run), .PRESCALE(prescale), .CMD(cmd), .STATUS(status), .GLOBAL_IRQ_ENABLE(gie),
        .IRQ_ENABLE_REG_B(ien), .BUS_PRIO_SET(bus_prio), .TIMER_PRIO_SET(tmr_prio), .BUS_IRQ(bus_irq),
        .TIMER_IRQ(tmr_irq), .BUS_IRQ_PRIO(bus_ip), .TIMER_IRQ_PRIO(tmr_ip));
    i2cb_peer peer_u (.dev_scl_oe(scl_oe), .dev_sda_oe(sda_oe), .pull_scl(pull_scl), .pull_sda(pull_sda),
        .scl(scl), .sda(sda));
    task automatic step(input int cnt);
        repeat (cnt) @(posedge mclk);
        #1;
    endtask : step
    // One-cycle software command
    task automatic cmd_pulse(input i2cb_cmd_t v);
        cmd = v;
        step(1);
        cmd = '0;
        step(1);
    endtask : cmd_pulse
    task automatic print_verdict;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : print_verdict
    task automatic t_reset;
        `CHK("scl_oe", 1'b0, scl_oe)
        `CHK("sda_oe", 1'b0, sda_oe)
        `CHK("status", 8'h80, status)
        `CHK("irqs", 2'h0, {bus_irq, tmr_irq})
        `CHK("prio", 4'h0, {bus_ip, tmr_ip})
        $display("test reset done");
    endtask : t_reset
    // Start by another master wakes the slave; bus interrupt gating
    task automatic t_ext_start;
        slave_en = 1;
        timer_run = 1;
        gie = 1;
        ien = 8'h81;
        step(2);
        pull_sda = 1;
        `WAIT_UNTIL(status.start_seen, 20)
        `CHK("attn", 1'b1, status.attn)
        step(2);
        `CHK("bus_irq", 1'b1, bus_irq)
        gie = 0;
        step(2);
        `CHK("bus_irq_gie_off", 1'b0, bus_irq)
        gie = 1;
        ien = 8'h80;
        step(2);
        `CHK("bus_irq_bit0_off", 1'b0, bus_irq)
        ien = 8'h81;
        c = '0;
        c.clr_start = 1;
        cmd_pulse(c);
        `CHK("start_clr", 1'b0, status.start_seen)
        $display("test ext_start done");
    endtask : t_ext_start
    // Slave receives a bit, then stretches the following low period
    task automatic t_slave_bit;
        pull_scl = 1;
        step(3);
        pull_scl = 0;
        `WAIT_UNTIL(status.bit_ready, 20)
        `CHK("rx_bit", 1'b0, status.rx_bit)
        pull_scl = 1;
        step(4);
        pull_scl = 0;
        step(4);
        `CHK("stretch_oe", 1'b1, scl_oe)
        `CHK("scl_low", 1'b0, scl)
        pull_sda = 0;
        c = '0;
        c.clr_ready = 1;
        cmd_pulse(c);
        `WAIT_UNTIL(scl, 10)
        $display("test slave_bit done");
    endtask : t_slave_bit
    // Hung frame: carry resets the interface and raises the timer interrupt
    task automatic t_timeout;
        step(2);
        pull_scl = 1;
        step(2);
        pull_scl = 0;
        `CHK("hang_hold", 1'b1, scl_oe)
        for (n = 0; n < 1200 && status.timeout !== 1'b1; n++) step(1);
        `CHK("carry_window", 1'b1, n >= 1020 && n <= 1023)
        `CHK("scl_oe", 1'b0, scl_oe)
        `CHK("bit_ready", 1'b0, status.bit_ready)
        step(2);
        `CHK("tmr_irq", 1'b1, tmr_irq)
        ien = 8'h01;
        step(2);
        `CHK("tmr_irq_bit7_off", 1'b0, tmr_irq)
        ien = 8'h81;
        c = '0;
        c.clr_timeout = 1;
        cmd_pulse(c);
        $display("test timeout done");
    endtask : t_timeout
    // After a stop the high part of the watch counter stands still
    task automatic t_stop_idle;
        pull_sda = 1;
        step(4);
        pull_sda = 0;
        `WAIT_UNTIL(status.stop_seen, 20)
        c = '0;
        c.clr_stop = 1;
        c.clr_start = 1;
        c.clr_ready = 1;
        c.go_idle = 1;
        cmd_pulse(c);
        step(1100);
        `CHK("no_timeout", 1'b0, status.timeout)
        pull_scl = 1;
        step(2);
        pull_scl = 0;
        step(2);
        `CHK("idle_ignores", 1'b0, status.bit_ready)
        $display("test stop_idle done");
    endtask : t_stop_idle
    task automatic t_prio;
        bus_prio = 2'h2;
        tmr_prio = 2'h1;
        step(2);
        `CHK("bus_prio", 2'h2, bus_ip)
        `CHK("tmr_prio", 2'h1, tmr_ip)
        $display("test prio done");
    endtask : t_prio
    // Own start, then arbitration lost on a sent one
    task automatic t_master_arb;
        master_req = 1;
        `WAIT_UNTIL(sda_oe, 200)
        for (n = 0; n < 100 && scl_oe !== 1'b1; n++) step(1);
        `CHK("start_hold", 1'b1, n >= 7 && n < 100)
        `CHK("is_master", 1'b1, status.is_master)
        `CHK("own_start", 1'b1, status.start_seen)
        pull_sda = 1;
        c = '0;
        c.clr_start = 1;
        c.wr_dat = 1;
        c.tx_bit = 1;
        cmd_pulse(c);
        `WAIT_UNTIL(status.arb_lost, 100)
        `CHK("lost_master", 1'b0, status.is_master)
        step(2);
        `CHK("sda_free", 1'b0, sda_oe)
        master_req = 0;
        pull_sda = 0;
        step(4);
        c = '0;
        c.clr_arb = 1;
        c.clr_stop = 1;
        c.clr_ready = 1;
        c.clr_xact = 1;
        cmd_pulse(c);
        `CHK("arb_clr", 1'b0, status.arb_lost)
        `CHK("attn_clr", 1'b0, status.attn)
        $display("test master_arb done");
    endtask : t_master_arb
    // Own zero bit at a shorter prescale, then a generated stop
    task automatic t_master_stop;
        prescale = 2'h3;
        master_req = 1;
        `WAIT_UNTIL(sda_oe, 200)
        for (n = 0; n < 100 && scl_oe !== 1'b1; n++) step(1);
        `CHK("start_hold_p3", 1'b1, n >= 5 && n < 10)
        c = '0;
        c.clr_start = 1;
        c.wr_dat = 1;
        cmd_pulse(c);
        `CHK("tx_zero", 1'b1, sda_oe)
        `WAIT_UNTIL(status.bit_ready, 100)
        `CHK("rx_own_zero", 1'b0, status.rx_bit)
        `WAIT_UNTIL(scl_oe, 100)
        c = '0;
        c.rd_dat = 1;
        c.gen_stop = 1;
        cmd_pulse(c);
        `WAIT_UNTIL(status.stop_seen, 200)
        master_req = 0;
        `CHK("stop_sda", 1'b1, sda)
        step(12);
        `CHK("master_done", 1'b0, status.is_master)
        `CHK("lines_free", 2'h0, {scl_oe, sda_oe})
        $display("test master_stop done");
    endtask : t_master_stop
    initial begin
        step(3);
        t_reset();
        arst_n = 1;
        step(1);
        t_ext_start();
        t_slave_bit();
        t_timeout();
        t_stop_idle();
        t_prio();
        t_master_arb();
        t_master_stop();
        print_verdict();
    end
endmodule : i2cb_core_tb

// *** i2cb_peer.sv ***
// Far-side bus party: other masters and slaves pulling the open-drain SCL and SDA lines
`timescale 1ns/1ps
module i2cb_peer (
    input wire logic dev_scl_oe,
    input wire logic dev_sda_oe,
    input wire logic pull_scl,
    input wire logic pull_sda,
    output logic scl,
    output logic sda
);
    // Wired-AND with pull-ups: a released line reads high, any party pulling wins
    assign scl = !(dev_scl_oe || pull_scl);
    assign sda = !(dev_sda_oe || pull_sda);
endmodule : i2cb_peer

// *** i2cb_pkg.sv ***
// Shared constants, state encoding and carrier types for the single-bit I2C interface
package i2cb_pkg;

    // Bus-watch counter shape: full width and the min-time low part
    localparam int WATCH_W = 10;
    localparam int LOW_W = 3;
    localparam logic [9:0] WATCH_FULL = 10'h03FF;
    localparam logic [2:0] LOW_FULL = 3'h7;

    // Preload of the low part per prescale code; carry lands 1023..1020 cycles after a change
    localparam logic [3:0][2:0] PRELOAD_TBL = {3'h3, 3'h2, 3'h1, 3'h0};

    // Bit positions inside the second interrupt enable register
    localparam int IRQ_BUS_BIT = 0;
    localparam int IRQ_TIMER_BIT = 7;

    // Default CPU clocks per machine cycle
    localparam int MCYCLE_DIV_DEF = 6;

    // Reset values
    localparam logic PIN_IDLE = 1'b1;
    localparam logic [1:0] PRIO_RST = 2'h0;

    // Master sequencer, Gray coded along idle-start-low-high-stop
    typedef enum logic [2:0] {
        M_IDLE = 3'h0,
        M_START_A = 3'h1,
        M_START_B = 3'h3,
        M_LOW = 3'h2,
        M_HIGH = 3'h6,
        M_STOP_A = 3'h7,
        M_STOP_B = 3'h5
    } i2cb_mst_t;

    // Software command pulses, one cycle each
    typedef struct packed {
        logic wr_dat;
        logic tx_bit;
        logic rd_dat;
        logic clr_ready;
        logic clr_arb;
        logic clr_start;
        logic clr_stop;
        logic clr_xact;
        logic go_idle;
        logic gen_start;
        logic gen_stop;
        logic clr_timeout;
    } i2cb_cmd_t;

    // Status seen by software
    typedef struct packed {
        logic rx_bit;
        logic attn;
        logic bit_ready;
        logic arb_lost;
        logic start_seen;
        logic stop_seen;
        logic is_master;
        logic timeout;
    } i2cb_stat_t;

endpackage : i2cb_pkg

// *** i2cb_watch.sv ***
// Bus-watch timer: min-time spans in the low bits, hung-bus carry over the full width
`timescale 1ns/1ps
module i2cb_watch
    import i2cb_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic tick,
    input wire logic enable,
    input wire logic run_hi,
    input wire logic restart,
    input wire logic [2:0] preload,
    output logic min_ok,
    output logic carry
);

    logic [WATCH_W-1:0] cnt_r;
    logic [WATCH_W-1:0] cnt_nxt;
    logic min_r;
    logic min_nxt;

    // Low part wrap marks one min-time span
    wire low_wrap = tick & (cnt_r[LOW_W-1:0] == LOW_FULL);
    wire [WATCH_W-1:0] cnt_inc = cnt_r + 10'h0001;
    wire [LOW_W-1:0] low_inc = cnt_r[LOW_W-1:0] + 3'h1;

    // Counter next value; high part runs only inside a frame
    always_comb begin
        cnt_nxt = cnt_r;
        if (!enable) begin
            cnt_nxt = '0;
        end else if (restart) begin
            cnt_nxt = {7'h00, preload};
        end else if (tick && run_hi) begin
            cnt_nxt = cnt_inc;
        end else if (tick) begin
            cnt_nxt = {cnt_r[WATCH_W-1:LOW_W], low_inc};
        end
    end

    assign min_nxt = enable & ~restart & (min_r | low_wrap);
    assign carry = enable & ~restart & tick & run_hi & (cnt_r == WATCH_FULL);
    assign min_ok = min_r;

    // Counter and min-time flag
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_r <= '0;
            min_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            min_r <= min_nxt;
        end
    end

    AST_WATCH_STOPPED: assert property (@(posedge clk) disable iff (!arst_n)
        enable && !run_hi && !restart ##1 enable |-> cnt_r[WATCH_W-1:LOW_W] == $past(cnt_r[WATCH_W-1:LOW_W]))
        else $error("watch high bits moved outside a frame");
    AST_WATCH_NO_EARLY: assert property (@(posedge clk) disable iff (!arst_n) restart |=> !carry [*8])
        else $error("watch carry too soon after restart");

endmodule : i2cb_watch
